// ==== verilog/grl_regs.vh ====
// Purpose: Register offsets, field positions, reset values and timing
//          counts for the grouped register hold-and-launch controller.
// Assumes: Byte-wide registers on a 16-bit register address.
// Notes:   Definitions only.
`ifndef GRL_REGS_VH
`define GRL_REGS_VH

// ****************************************************************
// Register offsets
// ****************************************************************
`define GRL_OFS_GRP0_CNT 16'h3460
`define GRL_OFS_GRP1_CNT 16'h3461
`define GRL_OFS_GRP2_CNT 16'h3462
`define GRL_OFS_GRP3_CNT 16'h3463
`define GRL_OFS_TIMING 16'h3464
`define GRL_OFS_FIRST_FR 16'h3465
`define GRL_OFS_SECOND_FR 16'h3466
`define GRL_OFS_OPER 16'h3467
`define GRL_OFS_CUR_BANK 16'h346C
`define GRL_OFS_CUR_FRAMES 16'h346D

// ****************************************************************
// Reset values
// ****************************************************************
`define GRL_RST_GRP_CNT 8'h40
`define GRL_RST_TIMING 8'h03
`define GRL_RST_FRAMES 8'h01
`define GRL_RST_OPER 8'h02

// ****************************************************************
// Field positions
// ****************************************************************
`define GRL_BIT_NOW 6
`define GRL_BIT_PRE 5
`define GRL_BIT_POST 4
`define GRL_PRI_HI 3
`define GRL_PRI_LO 2
`define GRL_ALT_HI 1
`define GRL_ALT_LO 0
`define GRL_BIT_AUTO 1
`define GRL_BIT_ONE 0

// ****************************************************************
// Timing counts
// ****************************************************************
// Cycles before the start-of-frame at which a pre-frame launch fires.
`define GRL_PRE_LEAD 8'h01
// Total buffer entries shared by the four groups.
`define GRL_BUF_DEPTH 256

`endif

// ==== verilog/grl_buf_mem.v ====
// Purpose: Shared 256-entry staging memory holding the grouped writes.
// Assumes: One write port, one read port, registered read data.
// Notes:   Each entry holds a 16-bit target address and 8-bit value.
`timescale 1ns/1ps
`default_nettype none
module grl_buf_mem (
   // Clock.
   input wire mclk,
   // Write port.
   input wire wr_en,
   input wire [7:0] wr_addr,
   input wire [23:0] wr_data,
   // Read port.
   input wire [7:0] rd_addr,
   output reg [23:0] rd_data_ff
);
   reg [23:0] mem [0:255];

   // Storage has no reset; software fills entries before launching.
   always @(posedge mclk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
      rd_data_ff <= mem[rd_addr];
   end
endmodule // grl_buf_mem
`default_nettype wire

// ==== verilog/grl_frame_ctr.v ====
// Purpose: Frame counter shared by both groups of the alternating mode.
// Assumes: One start-of-frame pulse per frame, one mclk wide.
// Notes:   Switch pulse fires at the frame that reaches the limit.
`timescale 1ns/1ps
`default_nettype none
module grl_frame_ctr (
   // Clock and reset.
   input wire mclk,
   input wire rst_b,
   // Control.
   input wire run,
   input wire sof,
   input wire [7:0] limit,
   // Status.
   output reg [7:0] count_ff,
   output reg switch_ff
);
   reg [7:0] nxt_count;
   reg nxt_switch;

   // Limit of zero is treated as one so the mode never stalls.
   always @* begin
      nxt_count = count_ff;
      nxt_switch = 1'b0;
      if (!run) begin
         nxt_count = 8'h00;
      end else if (sof) begin
         if ((count_ff + 8'h01) >= limit) begin
            nxt_count = 8'h00;
            nxt_switch = 1'b1;
         end else begin
            nxt_count = count_ff + 8'h01;
         end
      end
   end

   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         count_ff <= 8'h00;
         switch_ff <= 1'b0;
      end else begin
         count_ff <= nxt_count;
         switch_ff <= nxt_switch;
      end
   end
endmodule // grl_frame_ctr
`default_nettype wire

// ==== verilog/grl_launch.v ====
// Purpose: Grouped register hold-and-launch controller.
// Assumes: Byte register port synchronous to mclk; sof_pre and sof are
//          one-cycle pulses from the sensor core timing, sof_pre ahead.
// Notes:   Buffer writes land in the staging memory; a launch replays
//          one group onto the live-write port between frame edges.
//          Group bases are sums of lower counts, so software must keep
//          the total within the staging depth or groups overlap.
`timescale 1ns/1ps
`default_nettype none
`include "grl_regs.vh"
module grl_launch (
   // Clock and reset.
   input wire mclk,
   input wire rst_b,
   // Control register port.
   input wire reg_wr,
   input wire reg_rd,
   input wire [15:0] reg_addr,
   input wire [7:0] reg_wdata,
   output reg [7:0] reg_rdata_ff,
   // Group buffer fill port.
   input wire buf_wr,
   input wire [7:0] buf_idx,
   input wire [15:0] buf_addr,
   input wire [7:0] buf_data,
   // Sensor core frame timing.
   input wire sof_pre,
   input wire sof,
   // Live register write port.
   output reg live_wr_ff,
   output reg [15:0] live_addr_ff,
   output reg [7:0] live_data_ff,
   output reg busy_ff
);
   // Sequencer states, one-hot.
   localparam [2:0] ST_IDLE = 3'b001;
   localparam [2:0] ST_WAIT = 3'b010;
   localparam [2:0] ST_COPY = 3'b100;

   // Operation reset word, kept whole so single bits can be taken.
   localparam [7:0] RST_OPER = `GRL_RST_OPER;

   reg [7:0] grp_cnt_ff [0:3];
   reg [7:0] timing_ff, first_fr_ff, second_fr_ff;
   reg auto_ff, one_ff;
   reg [1:0] cur_bank_ff;
   reg on_second_ff;
   reg [2:0] state_ff;
   reg [7:0] rd_ptr_ff, left_ff;
   reg wait_pre_ff;
   reg rd_vld_ff;
   reg done_ff;
   wire [23:0] mem_q;
   wire [7:0] fr_count;
   wire fr_switch;

   // Base entry of a group: sum of the counts of lower groups.
   function [7:0] grp_base;
      input [1:0] g;
      input [31:0] c;
      reg [7:0] s;
      begin
         s = 8'h00;
         if (g > 2'd0) s = s + c[7:0];
         if (g > 2'd1) s = s + c[15:8];
         if (g > 2'd2) s = s + c[23:16];
         grp_base = s;
      end
   endfunction

   // One-hot slot of a byte offset inside the group count page.
   function [3:0] slot_hot;
      input [1:0] s;
      begin
         slot_hot = 4'h1 << s;
      end
   endfunction

   wire [31:0] cnt_pack = {grp_cnt_ff[3], grp_cnt_ff[2],
      grp_cnt_ff[1], grp_cnt_ff[0]};
   wire [1:0] pri_sel = timing_ff[`GRL_PRI_HI:`GRL_PRI_LO];
   wire [1:0] alt_sel = timing_ff[`GRL_ALT_HI:`GRL_ALT_LO];
   wire idle = state_ff == ST_IDLE;

   // Group count page decode; a write hits at most one slot of four.
   wire cnt_page = reg_wr && {reg_addr[15:2], 2'h0} == `GRL_OFS_GRP0_CNT;
   wire [3:0] cnt_hit = cnt_page ? slot_hot(reg_addr[1:0]) : 4'h0;

   // ****************************************************************
   // Staging memory and frame counter
   // ****************************************************************
   // the staging memory holds every group until its launch.
   grl_buf_mem u_mem (
      .mclk(mclk),
      .wr_en(buf_wr),
      .wr_addr(buf_idx),
      .wr_data({buf_addr, buf_data}),
      .rd_addr(rd_ptr_ff),
      .rd_data_ff(mem_q)
   );

   grl_frame_ctr u_fr (
      .mclk(mclk),
      .rst_b(rst_b),
      .run(auto_ff),
      .sof(sof),
      .limit(on_second_ff ? second_fr_ff : first_fr_ff),
      .count_ff(fr_count),
      .switch_ff(fr_switch)
   );

   // ****************************************************************
   // Register writes
   // ****************************************************************
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : g_cnt
         always @(posedge mclk or negedge rst_b) begin
            if (!rst_b) begin
               grp_cnt_ff[gi] <= `GRL_RST_GRP_CNT;
            end else if (cnt_hit[gi]) begin
               grp_cnt_ff[gi] <= reg_wdata;
            end
         end
      end
   endgenerate

   // frame counts, as well; with auto off the one-shot bit self-clears.
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         timing_ff <= `GRL_RST_TIMING;
         first_fr_ff <= `GRL_RST_FRAMES;
         second_fr_ff <= `GRL_RST_FRAMES;
         auto_ff <= RST_OPER[`GRL_BIT_AUTO];
         one_ff <= RST_OPER[`GRL_BIT_ONE];
      end else begin
         // Timing bit 7 is unused and always reads back as zero.
         if (reg_wr && reg_addr == `GRL_OFS_TIMING) begin
            timing_ff <= {1'b0, reg_wdata[6:0]};
         end
         if (reg_wr && reg_addr == `GRL_OFS_FIRST_FR) begin
            first_fr_ff <= reg_wdata;
         end
         if (reg_wr && reg_addr == `GRL_OFS_SECOND_FR) begin
            second_fr_ff <= reg_wdata;
         end
         // self clear; a new write in the done cycle wins.
         if (reg_wr && reg_addr == `GRL_OFS_OPER) begin
            auto_ff <= reg_wdata[`GRL_BIT_AUTO];
            one_ff <= reg_wdata[`GRL_BIT_ONE];
         end else if (done_ff) begin
            one_ff <= 1'b0;
         end
      end
   end

   // ****************************************************************
   // Launch sequencer
   // ****************************************************************
   // One-shot launches stage the primary group; auto switches stage
   // the group being switched to. Each launch replays one group.
   // A switch that lands while a replay runs is dropped; frames are far
   // longer than any group, so in use this cannot happen.
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         state_ff <= ST_IDLE;
         rd_ptr_ff <= 8'h00;
         left_ff <= 8'h00;
         wait_pre_ff <= 1'b0;
         rd_vld_ff <= 1'b0;
         done_ff <= 1'b0;
         cur_bank_ff <= 2'd0;
         on_second_ff <= 1'b0;
      end else begin
         done_ff <= 1'b0;
         rd_vld_ff <= 1'b0;
         case (state_ff)
            ST_IDLE: begin
               if (!auto_ff) begin
                  on_second_ff <= 1'b0;
               end
               if (auto_ff && fr_switch) begin
                  on_second_ff <= ~on_second_ff;
                  cur_bank_ff <= on_second_ff ? pri_sel : alt_sel;
                  rd_ptr_ff <= grp_base(on_second_ff ? pri_sel :
                     alt_sel, cnt_pack);
                  left_ff <= grp_cnt_ff[on_second_ff ? pri_sel : alt_sel];
                  state_ff <= ST_COPY;
               // auto overrides; done_ff masks the stale one-shot bit
               // in the cycle before it clears, or the group would replay.
               end else if (!auto_ff && one_ff && !done_ff) begin
                  cur_bank_ff <= pri_sel;
                  rd_ptr_ff <= grp_base(pri_sel, cnt_pack);
                  left_ff <= grp_cnt_ff[pri_sel];
                  if (timing_ff[`GRL_BIT_NOW]) begin
                     state_ff <= ST_COPY;
                  end else if (timing_ff[`GRL_BIT_PRE]) begin
                     wait_pre_ff <= 1'b1;
                     state_ff <= ST_WAIT;
                  end else if (timing_ff[`GRL_BIT_POST]) begin
                     wait_pre_ff <= 1'b0;
                     state_ff <= ST_WAIT;
                  end else begin
                     // No timing bit: drop the request as done.
                     done_ff <= 1'b1;
                  end
               end
            end
            ST_WAIT: begin
               if ((wait_pre_ff && sof_pre) || (!wait_pre_ff && sof)) begin
                  state_ff <= ST_COPY;
               end
            end
            ST_COPY: begin
               if (left_ff == 8'h00) begin
                  state_ff <= ST_IDLE;
                  done_ff <= !auto_ff;
               end else begin
                  rd_vld_ff <= 1'b1;
                  rd_ptr_ff <= rd_ptr_ff + 8'h01;
                  left_ff <= left_ff - 8'h01;
               end
            end
            default: begin
               state_ff <= ST_IDLE;
            end
         endcase
      end
   end

   // ****************************************************************
   // Live write port and read-back
   // ****************************************************************
   // Memory data lag the pointer by one cycle, matched by rd_vld_ff.
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         live_wr_ff <= 1'b0;
         live_addr_ff <= 16'h0000;
         live_data_ff <= 8'h00;
         busy_ff <= 1'b0;
      end else begin
         live_wr_ff <= rd_vld_ff;
         live_addr_ff <= rd_vld_ff ? mem_q[23:8] : live_addr_ff;
         live_data_ff <= rd_vld_ff ? mem_q[7:0] : live_data_ff;
         busy_ff <= !idle || rd_vld_ff;
      end
   end

   // active group, frame count; unmapped reads return zero.
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         reg_rdata_ff <= 8'h00;
      end else if (reg_rd) begin
         if (reg_addr == `GRL_OFS_GRP0_CNT) reg_rdata_ff <= grp_cnt_ff[0];
         else if (reg_addr == `GRL_OFS_GRP1_CNT)
            reg_rdata_ff <= grp_cnt_ff[1];
         else if (reg_addr == `GRL_OFS_GRP2_CNT)
            reg_rdata_ff <= grp_cnt_ff[2];
         else if (reg_addr == `GRL_OFS_GRP3_CNT)
            reg_rdata_ff <= grp_cnt_ff[3];
         else if (reg_addr == `GRL_OFS_TIMING) reg_rdata_ff <= timing_ff;
         else if (reg_addr == `GRL_OFS_FIRST_FR) reg_rdata_ff <= first_fr_ff;
         else if (reg_addr == `GRL_OFS_SECOND_FR)
            reg_rdata_ff <= second_fr_ff;
         else if (reg_addr == `GRL_OFS_OPER)
            reg_rdata_ff <= {6'b000000, auto_ff, one_ff};
         else if (reg_addr == `GRL_OFS_CUR_BANK)
            reg_rdata_ff <= {6'b000000, cur_bank_ff};
         // the count means nothing outside the alternating mode, and
         // the counter clears a cycle late, so the read is gated here.
         else if (reg_addr == `GRL_OFS_CUR_FRAMES)
            reg_rdata_ff <= auto_ff ? fr_count : 8'h00;
         else reg_rdata_ff <= 8'h00;
      end
   end
endmodule // grl_launch
`default_nettype wire

// ==== sim/grl_launch_props.sv ====
// Purpose: Port assertions for the grouped launch controller.
// Assumes: Only register port writes change the shadowed fields.
// Notes:   Bound to grl_launch below the module.
`timescale 1ns/1ps
`default_nettype none
`include "grl_regs.vh"
module grl_launch_props (
   // Clock and reset.
   input wire mclk,
   input wire rst_b,
   // Register port.
   input wire reg_wr,
   input wire reg_rd,
   input wire [15:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire [7:0] reg_rdata_ff,
   // Frame edge and live port.
   input wire sof,
   input wire live_wr_ff,
   input wire busy_ff
);
   // ****
   // Shadows and assertions
   // ****
   logic [7:0] tim_ff;
   logic auto_ff;
   wire op_wr = reg_wr && reg_addr == `GRL_OFS_OPER;
   // Shadow the timing and mode fields so reads can be predicted.
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         tim_ff <= `GRL_RST_TIMING;
         auto_ff <= 1'b1;
      end else begin
         if (reg_wr && reg_addr == `GRL_OFS_TIMING) tim_ff <= reg_wdata;
         if (op_wr) auto_ff <= reg_wdata[1];
      end
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);
   sequence s_cnt_wr;
      reg_wr && reg_addr == `GRL_OFS_GRP1_CNT;
   endsequence
   sequence s_cnt_rd;
      reg_rd && !reg_wr && reg_addr == `GRL_OFS_GRP1_CNT;
   endsequence
   a_read_data_hold: assert property (
      !reg_rd |=> $stable(reg_rdata_ff)) else $error("read data moved");
   a_unmapped_read_zero: assert property (
      reg_rd && (reg_addr < 16'h3460 || reg_addr > 16'h346D ||
      reg_addr[15:2] == 14'h0D1A) |=> reg_rdata_ff == 8'h00)
      else $error("unmapped read not zero");
   a_count_read_back: assert property (
      s_cnt_wr ##1 s_cnt_rd |=> reg_rdata_ff == $past(reg_wdata, 2))
      else $error("group count readback wrong");
   a_timing_mirror: assert property (
      reg_rd && !reg_wr && reg_addr == `GRL_OFS_TIMING
      |=> reg_rdata_ff == {1'b0, tim_ff[6:0]}) else $error("timing read");
   a_now_launch_start: assert property (
      op_wr && reg_wdata[1:0] == 2'b01 && tim_ff[6] && !busy_ff
      |-> ##[1:3] busy_ff) else $error("immediate launch not started");
   a_auto_one_ignored: assert property (
      op_wr && reg_wdata[1:0] == 2'b11 && !busy_ff && !sof && !$past(sof)
      && !$past(sof, 2) |=> !busy_ff ##1 !live_wr_ff
      ##1 (!busy_ff || $past(sof, 2)))
      else $error("one-shot acted in auto mode");
   a_live_needs_busy: assert property (
      live_wr_ff |-> $past(busy_ff)) else $error("live write while idle");
   a_frames_zero_off: assert property (
      reg_rd && !reg_wr && reg_addr == `GRL_OFS_CUR_FRAMES && !auto_ff
      |=> reg_rdata_ff == 8'h00) else $error("frame count not zero");
   a_bank_two_bits: assert property (
      reg_rd && reg_addr == `GRL_OFS_CUR_BANK |=> reg_rdata_ff[7:2] == 6'h00)
      else $error("bank index too wide");
endmodule // grl_launch_props
bind grl_launch grl_launch_props grl_launch_props_i (.mclk(mclk),
   .rst_b(rst_b), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff), .sof(sof),
   .live_wr_ff(live_wr_ff), .busy_ff(busy_ff));
`default_nettype wire

// ==== sim/grl_launch_tb.sv ====
// Purpose: Self-checking bench for the grouped launch controller.
// Assumes: Group counts sum to 7, well under the shared depth.
// Notes:   Live writes are logged mid-cycle and compared per launch.
`timescale 1ns/1ps
`default_nettype none
`include "grl_regs.vh"
module grl_launch_tb;
   // ****
   // Signals
   // ****
   logic mclk, rst_b, reg_wr, reg_rd, buf_wr, sof_pre, sof;
   logic [15:0] reg_addr, buf_addr;
   logic [7:0] reg_wdata, buf_idx, buf_data;
   wire [7:0] reg_rdata_ff, live_data_ff;
   wire [15:0] live_addr_ff;
   wire live_wr_ff, busy_ff;
   integer failures = 0, cmp_count = 0, cyc = 0, first = 0, seed = 32'hf3d5;
   integer i, p, t0, bank, fc;
   logic [23:0] lq[$];
   logic [23:0] mem [0:7];
   logic [7:0] cnt [0:3];
   grl_launch grl_launch_i (.mclk(mclk), .rst_b(rst_b), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_rdata_ff(reg_rdata_ff), .buf_wr(buf_wr), .buf_idx(buf_idx),
      .buf_addr(buf_addr), .buf_data(buf_data), .sof_pre(sof_pre),
      .sof(sof), .live_wr_ff(live_wr_ff), .live_addr_ff(live_addr_ff),
      .live_data_ff(live_data_ff), .busy_ff(busy_ff));
   // Free-running 25 MHz clock.
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   // Count edges; a hang past the ceiling ends the run as a failure.
   always @(posedge mclk) begin
      cyc = cyc + 1;
      if (cyc == 5000) begin
         failures = failures + 1;
         complete_run;
      end
   end
   // Log live writes at the falling edge, where they have settled.
   always @(negedge mclk) begin
      if (live_wr_ff === 1'b1) begin
         if (lq.size() == 0) first = cyc;
         lq.push_back({live_addr_ff, live_data_ff});
      end
   end
   // ****
   // Tasks
   // ****
   task chk(input logic [23:0] seen, input logic [23:0] exp);
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
         failures = failures + 1;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // Strobes stay as set until the next access or nap, so back-to-back
   // accesses never assign a strobe twice in one time step.
   task acc(input logic w, input logic r, input logic [15:0] a,
      input logic [7:0] d);
      reg_wr = w;
      reg_rd = r;
      reg_addr = a;
      reg_wdata = d;
      @(posedge mclk);
      #1;
   endtask
   task rd(input logic [15:0] a, input logic [7:0] e);
      acc(1'b0, 1'b1, a, 8'h00);
      chk({16'h0000, reg_rdata_ff}, {16'h0000, e});
   endtask
   task nap(input integer n);
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      buf_wr = 1'b0;
      sof = 1'b0;
      sof_pre = 1'b0;
      repeat (n) @(posedge mclk);
      #1;
   endtask
   // One frame-timing pulse, then a quiet spell for any replay.
   task frm(input logic pre);
      sof_pre = pre;
      sof = !pre;
      @(posedge mclk);
      #1;
      nap(10);
   endtask
   // Wait at least four edges, so a launch just taken has raised busy,
   // then for the launch to finish, and compare the replayed group.
   task launch_chk(input integer g, input integer dly);
      integer b, k;
      b = 0;
      for (k = 0; k < g; k = k + 1) b = b + cnt[k];
      for (k = 0; k < 60 && (k < 4 || busy_ff !== 1'b0); k = k + 1) begin
         @(posedge mclk);
         #1;
      end
      nap(3);
      chk(24'(lq.size()), 24'(cnt[g]));
      for (k = 0; k < lq.size(); k = k + 1) chk(lq[k], mem[b + k]);
      if (dly > 0) chk(24'(first - t0), 24'(dly));
      lq.delete();
   endtask
   task complete_run;
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // ****
   // Main sequence
   // ****
   initial begin
      rst_b = 1'b0;
      buf_idx = 8'h00;
      {buf_addr, buf_data} = 24'h000000;
      nap(10);
      rst_b = 1'b1;
      for (i = 0; i < 4; i = i + 1) rd(16'(16'h3460 + i), 8'h40);
      rd(`GRL_OFS_TIMING, 8'h03);
      rd(`GRL_OFS_FIRST_FR, 8'h01);
      rd(`GRL_OFS_SECOND_FR, 8'h01);
      rd(`GRL_OFS_OPER, 8'h02);
      rd(`GRL_OFS_CUR_FRAMES, 8'h00);
      acc(1'b1, 1'b0, `GRL_OFS_CUR_BANK, 8'hFF);
      rd(`GRL_OFS_CUR_BANK, 8'h00);
      rd(16'h3468, 8'h00);
      $display("reset values done");
      // Random values read back at once; timing bit 7 is not kept.
      for (i = 0; i < 8; i = i + 1) begin
         p = $random(seed);
         acc(1'b1, 1'b0, 16'(16'h3460 + i % 4), p[7:0]);
         rd(16'(16'h3460 + i % 4), p[7:0]);
         acc(1'b1, 1'b0, `GRL_OFS_TIMING, p[15:8] | 8'h80);
         rd(`GRL_OFS_TIMING, p[15:8] & 8'h7F);
         acc(1'b1, 1'b0, 16'(16'h3465 + i % 2), p[23:16]);
         rd(16'(16'h3465 + i % 2), p[23:16]);
      end
      nap(1);
      $display("random access done");
      // counts sum to 7, well inside the shared depth.
      cnt[0] = 8'h02;
      cnt[1] = 8'h03;
      cnt[2] = 8'h01;
      cnt[3] = 8'h01;
      for (i = 0; i < 4; i = i + 1) acc(1'b1, 1'b0, 16'(16'h3460 + i), cnt[i]);
      nap(1);
      for (i = 0; i < 8; i = i + 1) begin
         mem[i] = 24'($random(seed));
         buf_wr = 1'b1;
         buf_idx = 8'(i);
         {buf_addr, buf_data} = mem[i];
         @(posedge mclk);
         #1;
      end
      acc(1'b1, 1'b0, `GRL_OFS_TIMING, 8'h43);
      acc(1'b1, 1'b0, `GRL_OFS_FIRST_FR, 8'h03);
      acc(1'b1, 1'b0, `GRL_OFS_SECOND_FR, 8'h01);
      acc(1'b1, 1'b0, `GRL_OFS_OPER, 8'h03);
      acc(1'b1, 1'b0, `GRL_OFS_OPER, 8'h02);
      nap(8);
      chk(24'(lq.size()), 24'h000000);
      // Alternation: three frames on group 0, then one on group 3.
      bank = 0;
      fc = 0;
      for (i = 0; i < 7; i = i + 1) begin
         frm(1'b0);
         if (fc + 1 >= (bank == 0 ? 3 : 1)) begin
            bank = (bank == 0) ? 3 : 0;
            fc = 0;
         end else begin
            fc = fc + 1;
         end
         rd(`GRL_OFS_CUR_BANK, 8'(bank));
         rd(`GRL_OFS_CUR_FRAMES, 8'(fc));
      end
      lq.delete();
      acc(1'b1, 1'b0, `GRL_OFS_OPER, 8'h00);
      rd(`GRL_OFS_CUR_FRAMES, 8'h00);
      $display("alternation done");
      // Immediate launches; once all three timing bits are set together.
      for (p = 0; p < 3; p = p + 1) begin
         acc(1'b1, 1'b0, `GRL_OFS_TIMING, (p == 1 ? 8'h70 : 8'h40) | 8'(p << 2));
         acc(1'b1, 1'b0, `GRL_OFS_OPER, 8'h01);
         t0 = cyc;
         nap(1);
         launch_chk(p, 3);
         rd(`GRL_OFS_OPER, 8'h00);
         rd(`GRL_OFS_CUR_BANK, 8'(p));
      end
      $display("immediate launch done");
      // Frame-edge launches wait for their own edge; the post-frame one is also shown to ignore sof_pre.
      for (p = 0; p < 2; p = p + 1) begin
         acc(1'b1, 1'b0, `GRL_OFS_TIMING, p == 1 ? 8'h18 : 8'h24);
         acc(1'b1, 1'b0, `GRL_OFS_OPER, 8'h01);
         nap(6);
         chk(24'(lq.size()), 24'h000000);
         frm(1'b1);
         if (p == 1) begin
            chk(24'(lq.size()), 24'h000000);
            frm(1'b0);
         end
         launch_chk(p + 1, 0);
         rd(`GRL_OFS_OPER, 8'h00);
      end
      // A one-shot with no timing bit clears without any replay.
      acc(1'b1, 1'b0, `GRL_OFS_TIMING, 8'h0C);
      acc(1'b1, 1'b0, `GRL_OFS_OPER, 8'h01);
      nap(6);
      chk(24'(lq.size()), 24'h000000);
      rd(`GRL_OFS_OPER, 8'h00);
      $display("frame edge launch done");
      complete_run;
   end
endmodule // grl_launch_tb
`default_nettype wire
